//--- rtl/ata_cmd_pkg.sv
package ata_cmd_pkg;

  // ****************************************************************
  // Task-file register indices
  // ****************************************************************
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_ERROR = 3'h1;
  localparam logic [2:0] REG_COUNT = 3'h2;
  localparam logic [2:0] REG_ADDR_LOW = 3'h3;
  localparam logic [2:0] REG_ADDR_MID = 3'h4;
  localparam logic [2:0] REG_ADDR_HIGH = 3'h5;
  localparam logic [2:0] REG_DEVICE = 3'h6;
  localparam logic [2:0] REG_STATUS_CMD = 3'h7;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int ST_BUSY = 7;
  localparam int ST_READY = 6;
  localparam int ST_FAULT = 5;
  localparam int ST_DREQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_CRC = 7;
  localparam int ER_UNC = 6;
  localparam int ER_NOT_FOUND = 4;
  localparam int ER_ABORT = 2;
  localparam int DEV_LBA_MODE = 6;
  localparam int DEV_SELECT = 4;

  // ****************************************************************
  // Command codes and counts
  // ****************************************************************
  localparam logic [7:0] CMD_VERIFY = 8'h40;
  localparam logic [7:0] CMD_DMA_READ = 8'hC8;
  localparam logic [7:0] CMD_SET_MULTIPLE = 8'hC6;
  localparam logic [7:0] CMD_SLEEP = 8'hE6;
  localparam logic [7:0] BLOCK_SIZE_ONLY = 8'h01;
  localparam logic [8:0] SECTORS_FULL = 9'h100;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [7:0] RST_TASK_BYTE = 8'h00;
  localparam logic [7:0] RST_BLOCK_SIZE = 8'h01;

  typedef struct packed {
    logic [27:0] lba;
    logic to_host;
  } media_req_t;

  typedef struct packed {
    logic uncorrectable;
    logic not_found;
  } media_result_t;

  // A count byte of zero stands for the largest span.
  function automatic logic [8:0] sector_span(input logic [7:0] count);
    sector_span = (count == 8'h00) ? SECTORS_FULL : {1'b0, count};
  endfunction

endpackage

//--- rtl/sector_walker.sv
`timescale 1ns/100ps
`default_nettype none
module sector_walker
  import ata_cmd_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic [27:0] i_first_lba,
  input wire logic [8:0] i_sectors,
  input wire logic i_to_host,
  output logic o_req_valid,
  input wire logic i_req_ready,
  output media_req_t o_req,
  input wire logic i_done,
  input wire media_result_t i_result,
  output logic o_busy,
  output logic o_finish,
  output logic o_failed,
  output logic [27:0] o_fail_lba,
  output media_result_t o_fail_result
);

  logic issued;
  logic [27:0] lba;
  logic [8:0] remaining;
  logic to_host;
  logic fail_now;

  assign fail_now = issued && i_done && (i_result.uncorrectable || i_result.not_found);
  // One sector is asked for at a time, so a failure always names the first bad sector.
  assign o_req_valid = o_busy && !issued && !i_abort;
  assign o_req = '{lba: lba, to_host: to_host};

  // Walk consecutive sectors from the start address.
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_busy <= 1'b0;
      issued <= 1'b0;
      lba <= '0;
      remaining <= '0;
      to_host <= 1'b0;
    end
    else if (i_start && !o_busy)
    begin
      o_busy <= 1'b1;
      issued <= 1'b0;
      lba <= i_first_lba;
      remaining <= i_sectors;
      to_host <= i_to_host;
    end
    else if (o_busy)
    begin
      if (i_abort || fail_now || (issued && i_done && remaining == 9'h001))
      begin
        o_busy <= 1'b0;
        issued <= 1'b0;
      end
      else if (issued && i_done)
      begin
        issued <= 1'b0;
        lba <= lba + 28'h0000001;
        remaining <= remaining - 9'h001;
      end
      else if (o_req_valid && i_req_ready)
      begin
        issued <= 1'b1;
      end
    end
  end

  // Completion pulse and the first failing sector.
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_finish <= 1'b0;
      o_failed <= 1'b0;
      o_fail_lba <= '0;
      o_fail_result <= '0;
    end
    else
    begin
      o_finish <= o_busy && (i_abort || (issued && i_done && (fail_now || remaining == 9'h001)));
      if (i_start && !o_busy)
      begin
        o_failed <= 1'b0;
      end
      else if (o_busy && fail_now)
      begin
        o_failed <= 1'b1;
        o_fail_lba <= lba;
        o_fail_result <= i_result;
      end
    end
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  a_lba_advance: assert property (o_busy && issued && i_done && !fail_now && !i_abort && remaining > 9'h001
    |=> lba == $past(lba) + 28'h0000001 && remaining == $past(remaining) - 9'h001)
    else $error("sector address did not advance by one");

endmodule
`default_nettype wire

//--- rtl/ata_cmd_engine.sv
`timescale 1ns/100ps
`default_nettype none
module ata_cmd_engine
  import ata_cmd_pkg::*;
#(
  parameter logic DEVICE_NUMBER = 1'b0
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_tf_sel,
  input wire logic i_tf_wr,
  input wire logic i_tf_rd,
  input wire logic [7:0] i_tf_wdata,
  output logic [7:0] o_tf_rdata,
  output logic o_media_req_valid,
  input wire logic i_media_req_ready,
  output media_req_t o_media_req,
  input wire logic i_media_done,
  input wire media_result_t i_media_result,
  output logic o_dma_armed,
  input wire logic i_dma_ultra,
  input wire logic i_dma_crc_err,
  input wire logic i_dev_fault,
  output logic o_sleep,
  output logic [7:0] o_block_size
);

  // ****************************************************************
  // Task-file state
  // ****************************************************************
  typedef enum logic [0:0] {S_IDLE, S_WALK} state_t;

  state_t state;
  logic [7:0] count;
  logic [7:0] addr_low;
  logic [7:0] addr_mid;
  logic [7:0] addr_high;
  logic [7:0] device_sel;
  logic [7:0] error;
  logic busy;
  logic fault;
  logic walk_to_host;
  logic crc_seen;
  logic [7:0] status_byte;
  logic cmd_write;
  logic cmd_accept;
  logic walk_start;
  logic walk_abort;
  logic walk_busy;
  logic walk_finish;
  logic walk_failed;
  logic [27:0] walk_fail_lba;
  media_result_t walk_fail_result;
  logic [27:0] start_lba;
  logic [8:0] next_sectors;

  // Data request never rises: none of these commands moves PIO data.
  assign status_byte = {busy, !busy, fault, 1'b0, 1'b0, 2'b00, |error};
  assign start_lba = {device_sel[3:0], addr_high, addr_mid, addr_low};
  assign next_sectors = sector_span(count);
  assign cmd_write = i_tf_wr && i_tf_sel == REG_STATUS_CMD;
  // A command meant for the other device, or sent while busy or asleep, is dropped.
  assign cmd_accept = cmd_write && !busy && !o_sleep && device_sel[DEV_SELECT] == DEVICE_NUMBER;
  assign walk_start = cmd_accept && ((i_tf_wdata == CMD_VERIFY && device_sel[DEV_LBA_MODE])
    || i_tf_wdata == CMD_DMA_READ);
  // A CRC error in the DMA path ends the read at once.
  assign walk_abort = walk_to_host && i_dma_crc_err;

  // ****************************************************************
  // Sector sequencer
  // ****************************************************************
  sector_walker u_walker (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_start(walk_start),
    .i_abort(walk_abort),
    .i_first_lba(start_lba),
    .i_sectors(next_sectors),
    .i_to_host(i_tf_wdata == CMD_DMA_READ),
    .o_req_valid(o_media_req_valid),
    .i_req_ready(i_media_req_ready),
    .o_req(o_media_req),
    .i_done(i_media_done),
    .i_result(i_media_result),
    .o_busy(walk_busy),
    .o_finish(walk_finish),
    .o_failed(walk_failed),
    .o_fail_lba(walk_fail_lba),
    .o_fail_result(walk_fail_result)
  );

  // ****************************************************************
  // Command sequencing
  // ****************************************************************

  // Busy covers the media walk; non-data commands finish on the write itself.
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= S_IDLE;
      busy <= 1'b0;
      walk_to_host <= 1'b0;
      o_dma_armed <= 1'b0;
    end
    else
    begin
      unique case (state)
        S_IDLE:
        begin
          if (walk_start)
          begin
            state <= S_WALK;
            busy <= 1'b1;
            walk_to_host <= i_tf_wdata == CMD_DMA_READ;
            o_dma_armed <= i_tf_wdata == CMD_DMA_READ;
          end
        end
        S_WALK:
        begin
          if (walk_finish)
          begin
            state <= S_IDLE;
            busy <= 1'b0;
            walk_to_host <= 1'b0;
            o_dma_armed <= 1'b0;
          end
        end
      endcase
    end
  end

  // CRC errors only set the CRC bit in Ultra mode; in Multiword mode they still end the read, but unreported.
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      crc_seen <= 1'b0;
    end
    else if (walk_start)
    begin
      crc_seen <= 1'b0;
    end
    else if (state == S_WALK && walk_to_host && i_dma_crc_err && i_dma_ultra)
    begin
      crc_seen <= 1'b1;
    end
  end

  // Error byte: cleared by each accepted command, loaded at its end.
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      error <= RST_TASK_BYTE;
    end
    else if (cmd_accept)
    begin
      error <= RST_TASK_BYTE;
      if (i_tf_wdata == CMD_SET_MULTIPLE)
      begin
        error[ER_ABORT] <= count != BLOCK_SIZE_ONLY || i_dev_fault;
      end
      else if (i_tf_wdata == CMD_SLEEP)
      begin
        error[ER_ABORT] <= i_dev_fault;
      end
      else if (!walk_start)
      begin
        // Unknown codes, and verify without address mode, are aborted.
        error[ER_ABORT] <= 1'b1;
      end
    end
    else if (state == S_WALK && walk_finish)
    begin
      error[ER_UNC] <= walk_failed && walk_fail_result.uncorrectable;
      error[ER_NOT_FOUND] <= walk_failed && walk_fail_result.not_found;
      error[ER_CRC] <= crc_seen || (walk_abort && i_dma_ultra);
    end
  end

  // Fault is reported only by the mode and sleep commands.
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      fault <= 1'b0;
    end
    else if (cmd_accept)
    begin
      fault <= (i_tf_wdata == CMD_SET_MULTIPLE || i_tf_wdata == CMD_SLEEP) && i_dev_fault;
    end
  end

  // Block size: only one sector per block is ever taken.
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_block_size <= RST_BLOCK_SIZE;
    end
    else if (cmd_accept && i_tf_wdata == CMD_SET_MULTIPLE && count == BLOCK_SIZE_ONLY && !i_dev_fault)
    begin
      o_block_size <= count;
    end
  end

  // Sleep is left only through reset, so later commands are ignored.
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_sleep <= 1'b0;
    end
    else if (cmd_accept && i_tf_wdata == CMD_SLEEP && !i_dev_fault)
    begin
      o_sleep <= 1'b1;
    end
  end

  // ****************************************************************
  // Task-file registers
  // ****************************************************************

  // Host writes while busy are dropped; a failed walk reports its sector.
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      count <= RST_TASK_BYTE;
      addr_low <= RST_TASK_BYTE;
      addr_mid <= RST_TASK_BYTE;
      addr_high <= RST_TASK_BYTE;
      device_sel <= RST_TASK_BYTE;
    end
    else if (state == S_WALK && walk_finish && walk_failed)
    begin
      addr_low <= walk_fail_lba[7:0];
      addr_mid <= walk_fail_lba[15:8];
      addr_high <= walk_fail_lba[23:16];
      device_sel[3:0] <= walk_fail_lba[27:24];
    end
    else if (i_tf_wr && !busy)
    begin
      unique case (i_tf_sel)
        REG_COUNT: count <= i_tf_wdata;
        REG_ADDR_LOW: addr_low <= i_tf_wdata;
        REG_ADDR_MID: addr_mid <= i_tf_wdata;
        REG_ADDR_HIGH: addr_high <= i_tf_wdata;
        REG_DEVICE: device_sel <= i_tf_wdata;
        REG_DATA, REG_ERROR, REG_STATUS_CMD:
        begin
        end
      endcase
    end
  end

  // Read data is registered: it appears one edge after the read strobe.
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_tf_rdata <= RST_TASK_BYTE;
    end
    else if (i_tf_rd)
    begin
      unique case (i_tf_sel)
        REG_DATA: o_tf_rdata <= RST_TASK_BYTE;
        REG_ERROR: o_tf_rdata <= error;
        REG_COUNT: o_tf_rdata <= count;
        REG_ADDR_LOW: o_tf_rdata <= addr_low;
        REG_ADDR_MID: o_tf_rdata <= addr_mid;
        REG_ADDR_HIGH: o_tf_rdata <= addr_high;
        REG_DEVICE: o_tf_rdata <= device_sel;
        REG_STATUS_CMD: o_tf_rdata <= status_byte;
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  a_verify_no_data: assert property (state == S_WALK && !walk_to_host
    |-> !o_dma_armed && !(o_media_req_valid && o_media_req.to_host))
    else $error("verify moved data toward the host");

  a_err_mirror: assert property (status_byte[ST_ERR] == (|error) && !status_byte[ST_DREQ])
    else $error("status error bit disagrees with error byte");

  a_verify_starts: assert property (cmd_accept && i_tf_wdata == CMD_VERIFY && device_sel[DEV_LBA_MODE]
    |=> busy && state == S_WALK && !o_dma_armed)
    else $error("verify did not start a silent media walk");

  a_zero_count: assert property (walk_start && count == 8'h00 |-> next_sectors == 9'h100)
    else $error("zero count not taken as 256 sectors");

  a_done_ready: assert property ($fell(busy) |-> status_byte[ST_READY] && !status_byte[ST_BUSY] && !fault)
    else $error("completion without ready");

  a_fail_address: assert property (state == S_WALK && walk_finish && walk_failed
    |=> {device_sel[3:0], addr_high, addr_mid, addr_low} == $past(walk_fail_lba) && !busy)
    else $error("failing sector address not reported");

  a_unc_flag: assert property (state == S_WALK && walk_finish && walk_failed && walk_fail_result.uncorrectable
    |=> error[ER_UNC] && status_byte[ST_ERR])
    else $error("uncorrectable failure not flagged");

  a_crc_flag: assert property (state == S_WALK && walk_to_host && i_dma_crc_err && i_dma_ultra
    |-> ##[1:3] error[ER_CRC] && !busy)
    else $error("Ultra DMA CRC error not reported");

  a_block_size: assert property (cmd_accept && i_tf_wdata == CMD_SET_MULTIPLE && count != BLOCK_SIZE_ONLY
    |=> error[ER_ABORT] && o_block_size == $past(o_block_size))
    else $error("unsupported block size was not refused");

  a_sleep_enter: assert property (cmd_accept && i_tf_wdata == CMD_SLEEP && !i_dev_fault
    |=> o_sleep && !error[ER_ABORT])
    else $error("sleep command did not enter sleep");

  a_fault_abort: assert property (cmd_accept && i_tf_wdata == CMD_SLEEP && i_dev_fault
    |=> error[ER_ABORT] && status_byte[ST_FAULT] && !o_sleep)
    else $error("faulted sleep not aborted with fault");

endmodule
`default_nettype wire

//--- verification/media_model.sv
`timescale 1ns/100ps
`default_nettype none
// ********************
// Flash media stand-in
// ********************
module media_model
  import ata_cmd_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_req_valid,
  input wire media_req_t i_req,
  input wire logic [27:0] i_bad_lba,
  input wire media_result_t i_bad_kind,
  input wire logic i_slow,
  output logic o_ready,
  output logic o_done,
  output media_result_t o_result
);
  logic [8:0] taken;
  logic [27:0] first;
  logic [27:0] last;
  logic gap;
  logic dir;
  logic [27:0] lba;

  // One sector in flight; the result shows its inverse outside done so a late read is caught.
  initial
  begin
    o_ready = 1'b0;
    o_done = 1'b0;
    o_result = 2'h3;
    taken = 9'h000;
    gap = 1'b0;
    forever
    begin
      @(posedge i_ref_clk);
      #1;
      if (i_slow)
      begin
        repeat (3) @(posedge i_ref_clk);
        #1;
      end
      if (i_req_valid)
      begin
        lba = i_req.lba;
        dir = i_req.to_host;
        o_ready = 1'b1;
        @(posedge i_ref_clk);
        #1;
        o_ready = 1'b0;
        if (taken != 9'h000 && lba != last + 28'h1)
          gap = 1'b1;
        if (taken == 9'h000)
          first = lba;
        last = lba;
        taken = taken + 9'h001;
        o_done = 1'b1;
        o_result = (lba == i_bad_lba) ? i_bad_kind : 2'h0;
        @(posedge i_ref_clk);
        #1;
        o_done = 1'b0;
        o_result = ~o_result;
      end
    end
  end
endmodule
`default_nettype wire

//--- verification/tb_ata_verify_dma_mode_sleep_cmds.sv
`timescale 1ns/100ps
`default_nettype none
// ************************
// Command engine testbench
// ************************
module tb_ata_verify_dma_mode_sleep_cmds
  import ata_cmd_pkg::*;
;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] cnt;
    logic [7:0] dev;
    logic [8:0] bad;
    logic [1:0] kind;
    logic [7:0] st;
    logic [7:0] er;
    logic [8:0] n;
  } row_t;
  logic i_ref_clk;
  logic i_rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, ultra = 1'b0, crc = 1'b0, fault = 1'b0, slow = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic [27:0] bad_lba = 28'h0;
  media_result_t bad_kind = 2'h0;
  logic [7:0] rdata, blk, rv;
  logic req_valid, ready, done, armed, sleep;
  media_req_t req;
  media_result_t result;
  logic [27:0] start;
  int mismatches = 0;
  int check_count = 0;
  // Sector 0 of the table's address is 0AB1234 plus the device nibble.
  row_t rows [10] = '{
    '{CMD_VERIFY, 8'h03, 8'hE5, 9'h1FF, 2'h0, 8'h40, 8'h00, 9'h003},
    '{CMD_VERIFY, 8'h00, 8'hE5, 9'h1FF, 2'h0, 8'h40, 8'h00, 9'h100},
    '{CMD_VERIFY, 8'h04, 8'hE5, 9'h002, 2'h2, 8'h41, 8'h40, 9'h003},
    '{CMD_DMA_READ, 8'h01, 8'hE5, 9'h1FF, 2'h0, 8'h40, 8'h00, 9'h001},
    '{CMD_DMA_READ, 8'h02, 8'hE7, 9'h000, 2'h1, 8'h41, 8'h10, 9'h001},
    '{CMD_SET_MULTIPLE, 8'h01, 8'hE0, 9'h1FF, 2'h0, 8'h40, 8'h00, 9'h000},
    '{CMD_SET_MULTIPLE, 8'h08, 8'hE0, 9'h1FF, 2'h0, 8'h41, 8'h04, 9'h000},
    '{CMD_SET_MULTIPLE, 8'h00, 8'hE0, 9'h1FF, 2'h0, 8'h41, 8'h04, 9'h000},
    '{CMD_VERIFY, 8'h02, 8'hA5, 9'h1FF, 2'h0, 8'h41, 8'h04, 9'h000},
    '{8'h20, 8'h01, 8'hE0, 9'h1FF, 2'h0, 8'h41, 8'h04, 9'h000} // A code this block does not run is aborted.
  };

  ata_cmd_engine #(.DEVICE_NUMBER(1'b0)) dut_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_tf_sel(sel),
    .i_tf_wr(wr_en), .i_tf_rd(rd_en), .i_tf_wdata(wdata), .o_tf_rdata(rdata), .o_media_req_valid(req_valid),
    .i_media_req_ready(ready), .o_media_req(req), .i_media_done(done), .i_media_result(result),
    .o_dma_armed(armed), .i_dma_ultra(ultra), .i_dma_crc_err(crc), .i_dev_fault(fault), .o_sleep(sleep),
    .o_block_size(blk));

  media_model media_u (.i_ref_clk(i_ref_clk), .i_req_valid(req_valid), .i_req(req), .i_bad_lba(bad_lba),
    .i_bad_kind(bad_kind), .i_slow(slow), .o_ready(ready), .o_done(done), .o_result(result));

  // *************
  // Shared tasks
  // *************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // Strobes drop and an extra edge passes, so back-to-back calls never retoggle in one step.
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    sel = s;
    wdata = d;
    wr_en = 1'b1;
    @(posedge i_ref_clk);
    #1;
    wr_en = 1'b0;
    @(posedge i_ref_clk);
    #1;
  endtask

  task automatic rd(input logic [2:0] s);
    sel = s;
    rd_en = 1'b1;
    @(posedge i_ref_clk);
    #1;
    rd_en = 1'b0;
    @(posedge i_ref_clk);
    #1;
    rv = rdata;
  endtask

  task automatic issue(input logic [7:0] c, input logic [7:0] n, input logic [7:0] d);
    start = {d[3:0], 8'hAB, 8'h12, 8'h34};
    wr(REG_COUNT, n);
    wr(REG_ADDR_LOW, 8'h34);
    wr(REG_ADDR_MID, 8'h12);
    wr(REG_ADDR_HIGH, 8'hAB);
    wr(REG_DEVICE, d);
    media_u.taken = 9'h000;
    media_u.gap = 1'b0;
    rd(REG_STATUS_CMD);
    chk("ready", rv[ST_READY], 1'b1);
    wr(REG_STATUS_CMD, c);
  endtask

  // Polls status until busy falls; a hang counts against the run.
  task automatic wait_idle;
    int k;
    k = 0;
    rd(REG_STATUS_CMD);
    while (rv[ST_BUSY] !== 1'b0 && k < 3000)
    begin
      rd(REG_STATUS_CMD);
      k++;
    end
    if (k == 3000)
      mismatches++;
  endtask

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ***********
  // Stimulus
  // ***********
  initial
  begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  initial
  begin
    #(20 * 60000);
    mismatches++;
    report_and_stop();
  end

  initial
  begin
    repeat (12) @(posedge i_ref_clk);
    #1;
    i_rst = 1'b0;
    foreach (rows[i])
    begin
      bad_lba = {rows[i].dev[3:0], 8'hAB, 8'h12, 8'h34} + {19'h0, rows[i].bad};
      bad_kind = rows[i].kind;
      issue(rows[i].cmd, rows[i].cnt, rows[i].dev);
      wait_idle();
      chk("status", rv, rows[i].st);
      rd(REG_ERROR);
      chk("error", rv, rows[i].er);
      if (!(rows[i].cmd == CMD_DMA_READ && rows[i].er != 8'h00))
        chk("sectors", media_u.taken, rows[i].n);
      chk("gap", media_u.gap, 1'b0);
      if (rows[i].n != 9'h000)
      begin
        chk("first", media_u.first, start);
        chk("to host", media_u.dir, rows[i].cmd == CMD_DMA_READ);
      end
      rd(REG_DEVICE);
      chk("device bit", rv[DEV_SELECT], 1'b0);
      if (rows[i].bad != 9'h1FF)
      begin
        chk("fail top", rv[3:0], bad_lba[27:24]);
        rd(REG_ADDR_LOW);
        chk("fail low", rv, bad_lba[7:0]);
        rd(REG_ADDR_MID);
        chk("fail mid", rv, bad_lba[15:8]);
      end
      chk("block size", blk, 8'h01);
    end
    // CRC error mid-transfer, Ultra first and then Multiword.
    slow = 1'b1;
    for (int u = 1; u >= 0; u--)
    begin
      ultra = u[0];
      issue(CMD_DMA_READ, 8'h08, 8'hE0);
      for (int k = 0; k < 50 && armed !== 1'b1; k++)
        @(posedge i_ref_clk);
      #1;
      chk("armed", armed, 1'b1);
      crc = 1'b1;
      @(posedge i_ref_clk);
      #1;
      crc = 1'b0;
      wait_idle();
      chk("crc status", rv, u ? 8'h41 : 8'h40);
      chk("disarmed", armed, 1'b0);
      rd(REG_ERROR);
      chk("crc bit", rv[ER_CRC], u[0]);
    end
    slow = 1'b0;
    // A fault spoils both mode and sleep requests.
    fault = 1'b1;
    for (int j = 0; j < 2; j++)
    begin
      issue(j ? CMD_SLEEP : CMD_SET_MULTIPLE, 8'h01, 8'hE0);
      wait_idle();
      chk("fault status", rv, 8'h61);
      rd(REG_ERROR);
      chk("fault error", rv, 8'h04);
      chk("awake", sleep, 1'b0);
    end
    fault = 1'b0;
    issue(CMD_SLEEP, 8'h00, 8'hE0);
    wait_idle();
    chk("sleep status", rv, 8'h40);
    chk("asleep", sleep, 1'b1);
    issue(CMD_VERIFY, 8'h01, 8'hE5);
    wait_idle();
    chk("sleep refuses", media_u.taken, 9'h000);
    // Second reset in mid-run, then a command for the other device.
    i_rst = 1'b1;
    repeat (2) @(posedge i_ref_clk);
    #1;
    i_rst = 1'b0;
    chk("reset sleep", sleep, 1'b0);
    chk("reset block", blk, 8'h01);
    rd(REG_COUNT);
    chk("reset count", rv, 8'h00);
    issue(CMD_VERIFY, 8'h02, 8'hF5);
    wait_idle();
    chk("other device", rv, 8'h40);
    chk("other sectors", media_u.taken, 9'h000);
    report_and_stop();
  end
endmodule
`default_nettype wire
